// ==== core/dma_ctrl_defs.vh ====
// Register offsets, field positions and constants of the four-channel DMA block
`ifndef DMA_CTRL_DEFS_VH
`define DMA_CTRL_DEFS_VH
`define NCH 4
// Per-channel register block: base + 0x20 * channel
`define CH_STRIDE_SH 5
`define OFF_SRC_HI 5'h00
`define OFF_SRC_LO 5'h04
`define OFF_DST_HI 5'h08
`define OFF_DST_LO 5'h0C
`define OFF_COUNT 5'h10
`define OFF_ADDR_CTL 5'h14
`define OFF_TRIG_SEL 5'h18
`define OFF_CH_CTL 5'h1C
`define OFF_EN_STATUS 8'h80
// channel_control bits
`define CC_EN 0
`define CC_STG 1
`define CC_INIT 2
`define CC_MLE 3
`define CC_TC 7
// trigger_select_reg bits
`define TS_CODE_LO 0
`define TS_CODE_HI 2
`define TS_RAM_ACT 5
`define TS_OVF 6
`define TS_REQ 7
// addressing_control bits
`define AC_MODE 0
`define AC_SAD 2
`define AC_DAD 4
// internal_ram_select bit inside the high address registers
`define HI_IR 15
`define ADDR_STEP 32'h0000_0001
`define ZERO32 32'h0000_0000
`define CNT_ZERO 16'h0000
`define CNT_ONE 16'h0001
`endif

// ==== core/dma_ctrl.v ====
// Four-channel DMA controller: registers, arbitration and two-cycle transfer engine
//
// The placing of the registers and the APB register port are this design's own decisions.
`timescale 1ns/100ps
// Functional notes
// RULE1: Address and count registers are master/slave pairs; transfers use slave copy.
// RULE2: At terminal count the master values are copied into the slave stage.
// RULE3: Multi-link restarts automatically with new setup; end interrupt still raised.
// RULE4: While channel disabled, address and count writes update master and slave.
// RULE5: Once enabled and first trigger seen, writes reach only the master.
// RULE6: Master setup applies after terminal count plus next trigger request.
// RULE7: Multi-link restart does not need terminal count flag cleared.
// RULE8: Software must not soft-trigger while multi-link is enabled.
// RULE9: Each unit is a read of source then a write of destination.
// RULE10: Internal RAM to internal RAM transfers are not performed.
// RULE11: Fixed priority, channel 0 highest; single mode rearbitrates after each unit.
// RULE12: Block mode stays on the active channel until its block ends.
// RULE13: Hardware trigger starts when enabled and terminal count flag clear.
// RULE14: Soft trigger starts when enabled and terminal count flag clear.
// RULE15: Non-maskable input clears all enables, finishes unit, then allows acknowledge.
// RULE16: Re-enable resumes block from held request; single waits next request.
// RULE17: Resumed transfer keeps old settings until end or forced termination.
// RULE18: Writing force_terminate ends the channel's transfer.
// RULE19: addressing_control writes ignored while a transfer is active.
// RULE20: Transfer end sets terminal count flag and pulses transfer_end_irq.
// RULE21: Reading channel_control clears terminal count flag.
// RULE22: Software clears pending and overflow before enabling; 0x03 enables and triggers.
// RULE23: Pending and overflow set only by hardware; software may only clear (here a soft trigger also sets pending).
// RULE24: Enable clears at terminal count, forced termination or non-maskable input (here a multi-link channel stays enabled at terminal count).
`include "dma_ctrl_defs.vh"
module dma_ctrl (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire [7:0] periph_irq,
    input wire nmi_in,
    output reg nmi_ack_allow,
    output reg [3:0] transfer_end_irq,
    output reg bus_req,
    output reg bus_write,
    output reg [31:0] bus_addr,
    output reg [31:0] bus_wdata,
    output reg bus_ram,
    input wire [31:0] bus_rdata
);
    localparam ST_IDLE = 2'b00;
    localparam ST_READ = 2'b01;
    localparam ST_WRITE = 2'b10;

    wire wr_en = psel & penable & pwrite;
    wire rd_en = psel & penable & ~pwrite;
    // Read data latched in setup so it stands at the access edge
    wire rd_setup = psel & ~penable & ~pwrite;
    wire [1:0] ach = paddr[6:5];
    wire [4:0] aoff = paddr[4:0];
    wire in_ch = ~paddr[7];
    assign pready = 1'b1;
    assign pslverr = 1'b0;

    reg [1:0] state_q;
    reg [1:0] cur_q;
    reg [7:0] irq_s1_q, irq_s2_q, irq_s3_q;
    reg nmi_s1_q, nmi_s2_q;
    wire [7:0] irq_rise = irq_s2_q & ~irq_s3_q;

    reg [15:0] src_hi_m_q [0:3];
    reg [15:0] src_lo_m_q [0:3];
    reg [15:0] dst_hi_m_q [0:3];
    reg [15:0] dst_lo_m_q [0:3];
    reg [15:0] cnt_m_q [0:3];
    reg [31:0] src_s_q [0:3];
    reg [31:0] dst_s_q [0:3];
    reg [15:0] cnt_s_q [0:3];
    reg src_ir_q [0:3];
    reg dst_ir_q [0:3];
    reg [7:0] actl_q [0:3];
    reg [3:0] en_q, stg_q, mle_q, tc_q, req_q, ovf_q, trig_seen_q, act_q, pend_load_q;
    reg [2:0] code_q [0:3];
    reg [3:0] ramact_q;

    // Per-channel selected peripheral request, last unit of a transfer
    wire [3:0] hw_req;
    wire last_unit = (state_q == ST_WRITE) && (cnt_s_q[cur_q] == `CNT_ONE || cnt_s_q[cur_q] == `CNT_ZERO);
    genvar g;
    generate
        for (g = 0; g < `NCH; g = g + 1) begin : gen_req
            assign hw_req[g] = irq_rise[code_q[g]];
        end
    endgenerate
    wire [3:0] hw_take = hw_req & en_q & (~tc_q | mle_q);

    // RULE11: fixed priority pick
    wire [3:0] ready_ch = req_q & en_q;
    reg [1:0] pick;
    always @* begin
        pick = 2'd3;
        if (ready_ch[2])
            pick = 2'd2;
        if (ready_ch[1])
            pick = 2'd1;
        if (ready_ch[0])
            pick = 2'd0;
    end

    integer i;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_s1_q <= 8'h00;
            irq_s2_q <= 8'h00;
            irq_s3_q <= 8'h00;
            nmi_s1_q <= 1'b0;
            nmi_s2_q <= 1'b0;
        end else begin
            irq_s1_q <= periph_irq;
            irq_s2_q <= irq_s1_q;
            irq_s3_q <= irq_s2_q;
            nmi_s1_q <= nmi_in;
            nmi_s2_q <= nmi_s1_q;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ST_IDLE;
            cur_q <= 2'd0;
            bus_req <= 1'b0;
            bus_write <= 1'b0;
            bus_addr <= `ZERO32;
            bus_wdata <= `ZERO32;
            bus_ram <= 1'b0;
            nmi_ack_allow <= 1'b0;
            transfer_end_irq <= 4'h0;
            prdata <= `ZERO32;
            en_q <= 4'h0;
            stg_q <= 4'h0;
            mle_q <= 4'h0;
            tc_q <= 4'h0;
            req_q <= 4'h0;
            ovf_q <= 4'h0;
            trig_seen_q <= 4'h0;
            act_q <= 4'h0;
            pend_load_q <= 4'h0;
            ramact_q <= 4'h0;
            for (i = 0; i < `NCH; i = i + 1) begin
                src_hi_m_q[i] <= `CNT_ZERO;
                src_lo_m_q[i] <= `CNT_ZERO;
                dst_hi_m_q[i] <= `CNT_ZERO;
                dst_lo_m_q[i] <= `CNT_ZERO;
                cnt_m_q[i] <= `CNT_ZERO;
                src_s_q[i] <= `ZERO32;
                dst_s_q[i] <= `ZERO32;
                cnt_s_q[i] <= `CNT_ZERO;
                src_ir_q[i] <= 1'b0;
                dst_ir_q[i] <= 1'b0;
                actl_q[i] <= 8'h00;
                code_q[i] <= 3'd0;
            end
        end else begin
            transfer_end_irq <= 4'h0;
            stg_q <= 4'h0;
            nmi_ack_allow <= 1'b0;
            // Request capture by hardware or software
            for (i = 0; i < `NCH; i = i + 1) begin
                // RULE13: hardware trigger start
                if (hw_take[i]) begin
                    // RULE23: hardware sets pending and overflow
                    if (req_q[i])
                        ovf_q[i] <= 1'b1;
                    req_q[i] <= 1'b1;
                    trig_seen_q[i] <= 1'b1;
                    // RULE6: next trigger makes master setup effective
                    // RULE7: restart without flag clear in multi-link
                    if (pend_load_q[i] && !act_q[i]) begin
                        src_s_q[i] <= {src_hi_m_q[i], src_lo_m_q[i]};
                        dst_s_q[i] <= {dst_hi_m_q[i], dst_lo_m_q[i]};
                        cnt_s_q[i] <= cnt_m_q[i];
                        pend_load_q[i] <= 1'b0;
                        tc_q[i] <= 1'b0;
                    end
                end
                // RULE14: software trigger start
                if (stg_q[i] && en_q[i] && !tc_q[i]) begin
                    req_q[i] <= 1'b1;
                    trig_seen_q[i] <= 1'b1;
                end
            end
            // RULE9: read source, then write destination
            case (state_q)
                ST_IDLE: begin
                    bus_req <= 1'b0;
                    // RULE10: RAM to RAM pair never starts
                    if (|ready_ch && !nmi_s2_q && !(src_ir_q[pick] && dst_ir_q[pick])) begin
                        cur_q <= pick;
                        act_q[pick] <= 1'b1;
                        state_q <= ST_READ;
                        bus_req <= 1'b1;
                        bus_write <= 1'b0;
                        // RULE1: slave copy drives the transfer
                        bus_addr <= src_s_q[pick];
                        bus_ram <= src_ir_q[pick];
                    end else if (|ready_ch && !nmi_s2_q) begin
                        req_q[pick] <= 1'b0;
                    end
                end
                ST_READ: begin
                    bus_write <= 1'b1;
                    bus_addr <= dst_s_q[cur_q];
                    bus_wdata <= bus_rdata;
                    bus_ram <= dst_ir_q[cur_q];
                    state_q <= ST_WRITE;
                end
                ST_WRITE: begin
                    bus_req <= 1'b0;
                    bus_write <= 1'b0;
                    state_q <= ST_IDLE;
                    src_s_q[cur_q] <= actl_q[cur_q][`AC_SAD] ? src_s_q[cur_q] - `ADDR_STEP
                        : src_s_q[cur_q] + `ADDR_STEP;
                    dst_s_q[cur_q] <= actl_q[cur_q][`AC_DAD] ? dst_s_q[cur_q] - `ADDR_STEP
                        : dst_s_q[cur_q] + `ADDR_STEP;
                    cnt_s_q[cur_q] <= cnt_s_q[cur_q] - `CNT_ONE;
                    if (last_unit) begin
                        // RULE20: end sets flag and pulses interrupt
                        tc_q[cur_q] <= 1'b1;
                        transfer_end_irq[cur_q] <= 1'b1;
                        req_q[cur_q] <= 1'b0;
                        act_q[cur_q] <= 1'b0;
                        trig_seen_q[cur_q] <= 1'b0;
                        // RULE2: reload slave from master
                        src_s_q[cur_q] <= {src_hi_m_q[cur_q], src_lo_m_q[cur_q]};
                        dst_s_q[cur_q] <= {dst_hi_m_q[cur_q], dst_lo_m_q[cur_q]};
                        cnt_s_q[cur_q] <= cnt_m_q[cur_q];
                        pend_load_q[cur_q] <= 1'b0;
                        // RULE3: multi-link stays enabled for next setup
                        // RULE24: enable drops at terminal count unless multi-link
                        if (!mle_q[cur_q])
                            en_q[cur_q] <= 1'b0;
                    end else if (!actl_q[cur_q][`AC_MODE]) begin
                        // RULE11: single mode releases after each unit
                        req_q[cur_q] <= 1'b0;
                    end else if (en_q[cur_q] && !nmi_s2_q) begin
                        // RULE12: block mode keeps the channel
                        state_q <= ST_READ;
                        bus_req <= 1'b1;
                        bus_addr <= actl_q[cur_q][`AC_SAD] ? src_s_q[cur_q] - `ADDR_STEP
                            : src_s_q[cur_q] + `ADDR_STEP;
                        bus_ram <= src_ir_q[cur_q];
                    end
                    // RULE15: acknowledge allowed after unit completes
                    if (nmi_s2_q)
                        nmi_ack_allow <= 1'b1;
                end
                default: state_q <= ST_IDLE;
            endcase
            // RULE15: all enables cleared by non-maskable input
            // RULE24: enable dropped on non-maskable input
            // RULE16: held block request survives for resume
            if (nmi_s2_q) begin
                en_q <= 4'h0;
                if (state_q == ST_IDLE)
                    nmi_ack_allow <= 1'b1;
            end
            // Register writes
            if (wr_en && in_ch) begin
                case (aoff)
                    `OFF_SRC_HI, `OFF_SRC_LO, `OFF_DST_HI, `OFF_DST_LO, `OFF_COUNT: begin
                        if (aoff == `OFF_SRC_HI) begin
                            src_hi_m_q[ach] <= pwdata[15:0];
                            src_ir_q[ach] <= pwdata[`HI_IR];
                        end
                        if (aoff == `OFF_SRC_LO)
                            src_lo_m_q[ach] <= pwdata[15:0];
                        if (aoff == `OFF_DST_HI) begin
                            dst_hi_m_q[ach] <= pwdata[15:0];
                            dst_ir_q[ach] <= pwdata[`HI_IR];
                        end
                        if (aoff == `OFF_DST_LO)
                            dst_lo_m_q[ach] <= pwdata[15:0];
                        if (aoff == `OFF_COUNT)
                            cnt_m_q[ach] <= pwdata[15:0];
                        // RULE4: disabled channel with no active transfer writes both stages
                        if (!en_q[ach] && !act_q[ach]) begin
                            if (aoff == `OFF_SRC_HI)
                                src_s_q[ach] <= {pwdata[15:0], src_s_q[ach][15:0]};
                            if (aoff == `OFF_SRC_LO)
                                src_s_q[ach] <= {src_s_q[ach][31:16], pwdata[15:0]};
                            if (aoff == `OFF_DST_HI)
                                dst_s_q[ach] <= {pwdata[15:0], dst_s_q[ach][15:0]};
                            if (aoff == `OFF_DST_LO)
                                dst_s_q[ach] <= {dst_s_q[ach][31:16], pwdata[15:0]};
                            if (aoff == `OFF_COUNT)
                                cnt_s_q[ach] <= pwdata[15:0];
                        end else begin
                            // RULE5: master only once running
                            // RULE17: resumed transfer keeps slave setup
                            pend_load_q[ach] <= 1'b1;
                        end
                    end
                    `OFF_ADDR_CTL: begin
                        // RULE19: ignored while transfer active
                        if (!act_q[ach])
                            actl_q[ach] <= pwdata[7:0];
                    end
                    `OFF_TRIG_SEL: begin
                        code_q[ach] <= pwdata[`TS_CODE_HI:`TS_CODE_LO];
                        ramact_q[ach] <= pwdata[`TS_RAM_ACT];
                        // RULE23: software can only clear
                        if (!pwdata[`TS_REQ] && !hw_take[ach])
                            req_q[ach] <= 1'b0;
                        if (!pwdata[`TS_OVF] && !hw_take[ach])
                            ovf_q[ach] <= 1'b0;
                    end
                    `OFF_CH_CTL: begin
                        // RULE22: 0x03 enables and triggers together
                        en_q[ach] <= pwdata[`CC_EN];
                        stg_q[ach] <= pwdata[`CC_STG];
                        mle_q[ach] <= pwdata[`CC_MLE];
                        // RULE18: force termination
                        // RULE24: enable dropped on termination
                        if (pwdata[`CC_INIT]) begin
                            en_q[ach] <= 1'b0;
                            act_q[ach] <= 1'b0;
                            req_q[ach] <= 1'b0;
                            trig_seen_q[ach] <= 1'b0;
                            src_s_q[ach] <= {src_hi_m_q[ach], src_lo_m_q[ach]};
                            dst_s_q[ach] <= {dst_hi_m_q[ach], dst_lo_m_q[ach]};
                            cnt_s_q[ach] <= cnt_m_q[ach];
                            pend_load_q[ach] <= 1'b0;
                            if (state_q != ST_IDLE && cur_q == ach) begin
                                state_q <= ST_IDLE;
                                bus_req <= 1'b0;
                                bus_write <= 1'b0;
                            end
                        end
                    end
                    default: ;
                endcase
            end
            if (wr_en && paddr == `OFF_EN_STATUS)
                en_q <= pwdata[3:0];
            // Register reads
            if (rd_setup) begin
                prdata <= `ZERO32;
                if (in_ch) begin
                    case (aoff)
                        `OFF_SRC_HI: prdata <= {16'h0000, src_hi_m_q[ach]};
                        `OFF_SRC_LO: prdata <= {16'h0000, src_lo_m_q[ach]};
                        `OFF_DST_HI: prdata <= {16'h0000, dst_hi_m_q[ach]};
                        `OFF_DST_LO: prdata <= {16'h0000, dst_lo_m_q[ach]};
                        `OFF_COUNT: prdata <= {16'h0000, cnt_s_q[ach]};
                        `OFF_ADDR_CTL: prdata <= {24'h000000, actl_q[ach]};
                        `OFF_TRIG_SEL: prdata <= {24'h000000, req_q[ach], ovf_q[ach], ramact_q[ach],
                            2'b00, code_q[ach]};
                        `OFF_CH_CTL: prdata <= {24'h000000, tc_q[ach], 3'b000, mle_q[ach], 2'b00, en_q[ach]};
                        default: prdata <= `ZERO32;
                    endcase
                end else if (paddr == `OFF_EN_STATUS) begin
                    prdata <= {28'h0000000, en_q};
                end
            end
            // RULE21: access clears only a flag that was returned; a new end wins
            if (rd_en && in_ch && aoff == `OFF_CH_CTL && prdata[`CC_TC] && !(last_unit && cur_q == ach))
                tc_q[ach] <= 1'b0;
        end
    end
endmodule

// ==== tb/dma_ctrl_asserts.sv ====
// Concurrent checks on the ports of the DMA controller
`timescale 1ns/100ps
module dma_ctrl_asserts (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire [7:0] periph_irq,
    input wire nmi_in,
    input wire nmi_ack_allow,
    input wire [3:0] transfer_end_irq,
    input wire bus_req,
    input wire bus_write,
    input wire [31:0] bus_addr,
    input wire [31:0] bus_wdata,
    input wire bus_ram,
    input wire [31:0] bus_rdata
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // Eight cycles covers the sync stages plus one unfinished unit
    sequence nmi_held;
        nmi_in [*8];
    endsequence
    // Force terminate may cut a unit right after its read
    sequence read_cycle;
        bus_req && !bus_write && !(psel && penable && pwrite && paddr[4:0] == 5'h1C && pwdata[2]);
    endsequence
    pready_high_a: assert property (psel && penable |-> pready) else $error("apb not ready");
    no_slverr_a: assert property (!pslverr) else $error("apb error response");
    read_then_write_a: assert property (read_cycle |=> bus_req && bus_write) else $error("read not followed by write");
    write_after_read_a: assert property (bus_write |-> $past(bus_req) && !$past(bus_write)) else $error("write without read");
    write_data_a: assert property ($rose(bus_write) |-> bus_wdata == $past(bus_rdata)) else $error("write data not read data");
    unit_release_a: assert property (bus_req && bus_write |=> !(bus_req && bus_write)) else $error("bus not released after unit");
    end_pulse_a: assert property (transfer_end_irq != 4'h0 |=> (transfer_end_irq & $past(transfer_end_irq)) == 4'h0) else $error("end irq too long");
    nmi_idle_a: assert property (nmi_held |-> !bus_req) else $error("transfer during nmi");
    nmi_ack_phase_a: assert property (nmi_ack_allow && bus_req |-> bus_write) else $error("nmi ack mid unit");
endmodule

// ==== tb/far_side_model.sv ====
// Peripheral and internal RAM answering the transfer bus
`timescale 1ns/100ps
module far_side_model (
    input wire pclk,
    input wire presetn,
    input wire bus_req,
    input wire bus_write,
    input wire [31:0] bus_addr,
    output wire [31:0] bus_rdata
);
    reg [31:0] junk_q;
    // Outside a read the data lines carry a pattern that flips every cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) junk_q <= 32'h5A5A_A5A5;
        else junk_q <= ~junk_q;
    end
    // read data only in read cycle
    assign bus_rdata = (bus_req && !bus_write) ? {16'hC3C3, ~bus_addr[15:0]} : junk_q;
endmodule

// ==== tb/tb_top.sv ====
// Register level bench for the DMA controller
`timescale 1ns/100ps
module tb_top;
    reg pclk, presetn, psel, penable, pwrite, nmi_in;
    reg [7:0] paddr, periph_irq;
    reg [31:0] pwdata, rd_v;
    reg [3:0] irq_seen;
    reg ack_seen;
    wire [31:0] prdata, bus_addr, bus_wdata, bus_rdata;
    wire pready, pslverr, nmi_ack_allow, bus_req, bus_write, bus_ram;
    wire [3:0] transfer_end_irq;
    integer fail_count, checks_done, n_wr, n_rd, k;
    reg [15:0] wr_a [0:511];
    reg [31:0] wr_d [0:511];
    reg wr_m [0:511];
    reg [15:0] rd_a [0:511];
    dma_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .periph_irq(periph_irq), .nmi_in(nmi_in), .nmi_ack_allow(nmi_ack_allow),
        .transfer_end_irq(transfer_end_irq), .bus_req(bus_req), .bus_write(bus_write),
        .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_ram(bus_ram), .bus_rdata(bus_rdata));
    far_side_model far (.pclk(pclk), .presetn(presetn), .bus_req(bus_req), .bus_write(bus_write),
        .bus_addr(bus_addr), .bus_rdata(bus_rdata));
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        if (bus_req === 1'b1 && bus_write === 1'b0) begin
            rd_a[n_rd] = bus_addr[15:0];
            n_rd = n_rd + 1;
        end
        if (bus_req === 1'b1 && bus_write === 1'b1) begin
            wr_a[n_wr] = bus_addr[15:0];
            wr_d[n_wr] = bus_wdata;
            wr_m[n_wr] = bus_ram;
            n_wr = n_wr + 1;
        end
        irq_seen = irq_seen | transfer_end_irq;
        ack_seen = ack_seen | nmi_ack_allow;
    end
    task check(input [127:0] nm, input [31:0] seen, input [31:0] exp);
        begin
            checks_done = checks_done + 1;
            if (seen !== exp) begin
                fail_count = fail_count + 1;
                $display("CHECK FAILED %0s expected %h seen %h", nm, exp, seen);
            end
        end
    endtask
    task apb(input wr, input [7:0] a, input [31:0] d);
        begin
            @(posedge pclk);
            psel <= 1'b1;
            pwrite <= wr;
            paddr <= a;
            pwdata <= d;
            @(posedge pclk);
            penable <= 1'b1;
            @(posedge pclk);
            while (pready !== 1'b1)
                @(posedge pclk);
            rd_v = prdata;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    task cfg(input [7:0] b, input [15:0] sh, input [15:0] sl, input [15:0] dh, input [15:0] dl,
        input [15:0] cnt, input [7:0] md, input [7:0] tr);
        begin
            apb(1'b1, b, {16'h0000, sh});
            apb(1'b1, b + 8'h04, {16'h0000, sl});
            apb(1'b1, b + 8'h08, {16'h0000, dh});
            apb(1'b1, b + 8'h0C, {16'h0000, dl});
            apb(1'b1, b + 8'h10, {16'h0000, cnt});
            apb(1'b1, b + 8'h14, {24'h000000, md});
            apb(1'b1, b + 8'h18, {24'h000000, tr});
        end
    endtask
    task wait_wr(input integer n);
        integer w;
        begin
            w = 0;
            while (n_wr < n && w < 3000) begin
                w = w + 1;
                @(posedge pclk);
            end
            check("unit_count", (n_wr >= n), 32'h1);
        end
    endtask
    task print_verdict;
        begin
            if (fail_count == 0 && checks_done > 0) $display("STATUS OK");
            else $display("STATUS NOT OK");
            $finish;
        end
    endtask
    initial begin
        #1000000;
        fail_count = fail_count + 1;
        print_verdict;
    end
    initial begin
        {presetn, psel, penable, pwrite, nmi_in, ack_seen} = 6'h00;
        {paddr, periph_irq, irq_seen, pwdata, rd_v} = 0;
        {fail_count, checks_done, n_wr, n_rd} = 0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 8'h1C, 32'h0);
        check("ctl_reset", rd_v, 32'h0);
        apb(1'b0, 8'h84, 32'h0);
        check("unmapped", rd_v, 32'h0);
        // Block transfer to RAM started by one 0x03 write
        cfg(8'h00, 16'h0000, 16'h0010, 16'h8000, 16'h0020, 16'h0002, 8'h01, 8'h00);
        apb(1'b1, 8'h1C, 32'h3);
        wait_wr(2);
        check("dst0", wr_a[0], 16'h0020);
        check("dst1", wr_a[1], 16'h0021);
        check("src0", rd_a[0], 16'h0010);
        check("data0", wr_d[0], 32'hC3C3FFEF);
        check("data1", wr_d[1], 32'hC3C3FFEE);
        check("ram_dst", wr_m[0], 1'b1);
        repeat (4) @(posedge pclk);
        check("end_irq", irq_seen, 4'h1);
        apb(1'b0, 8'h1C, 32'h0);
        check("tc_set", rd_v & 32'h81, 32'h80);
        apb(1'b0, 8'h1C, 32'h0);
        check("tc_clear", rd_v & 32'h80, 32'h0);
        apb(1'b0, 8'h10, 32'h0);
        check("reload", rd_v, 32'h2);
        // Two single mode channels on one request line
        cfg(8'h00, 16'h0000, 16'h0100, 16'h0000, 16'h0300, 16'h0001, 8'h00, 8'h03);
        cfg(8'h20, 16'h0000, 16'h0200, 16'h0000, 16'h0400, 16'h0001, 8'h00, 8'h03);
        apb(1'b1, 8'h1C, 32'h1);
        apb(1'b1, 8'h3C, 32'h1);
        periph_irq <= 8'h08;
        wait_wr(4);
        check("prio_hi", rd_a[2], 16'h0100);
        check("prio_lo", rd_a[3], 16'h0200);
        periph_irq <= 8'h00;
        apb(1'b0, 8'h3C, 32'h0);
        apb(1'b1, 8'h38, 32'hC3);
        apb(1'b0, 8'h38, 32'h0);
        check("hw_flags", rd_v & 32'hFF, 32'h03);
        // RAM to RAM is never moved
        cfg(8'h20, 16'h8000, 16'h0500, 16'h8000, 16'h0600, 16'h0001, 8'h00, 8'h00);
        apb(1'b1, 8'h3C, 32'h3);
        repeat (30) @(posedge pclk);
        check("ram_ram", n_wr, 4);
        // Long block stopped by force terminate
        cfg(8'h40, 16'h0000, 16'h0700, 16'h0000, 16'h0800, 16'h0080, 8'h01, 8'h00);
        apb(1'b1, 8'h5C, 32'h3);
        wait_wr(7);
        apb(1'b1, 8'h5C, 32'h4);
        repeat (6) @(posedge pclk);
        k = n_wr;
        apb(1'b0, 8'h80, 32'h0);
        check("force_en", rd_v & 32'h4, 32'h0);
        check("force_stop", n_wr, k);
        // Block interrupted by nmi, then resumed
        cfg(8'h60, 16'h0000, 16'h0900, 16'h0000, 16'h0A00, 16'h0080, 8'h01, 8'h00);
        apb(1'b1, 8'h7C, 32'h3);
        wait_wr(k + 3);
        nmi_in <= 1'b1;
        repeat (12) @(posedge pclk);
        apb(1'b0, 8'h80, 32'h0);
        check("nmi_en", rd_v & 32'hF, 32'h0);
        check("nmi_ack", ack_seen, 1'b1);
        k = n_wr;
        repeat (10) @(posedge pclk);
        check("nmi_stop", n_wr, k);
        nmi_in <= 1'b0;
        repeat (4) @(posedge pclk);
        apb(1'b1, 8'h7C, 32'h1);
        wait_wr(k + 2);
        check("resume", wr_a[k] - wr_a[k - 1], 16'h0001);
        apb(1'b1, 8'h7C, 32'h4);
        repeat (10) @(posedge pclk);
        apb(1'b0, 8'h1C, 32'h0);
        cfg(8'h00, 16'h0000, 16'h0B00, 16'h0000, 16'h0C00, 16'h0001, 8'h00, 8'h03);
        apb(1'b1, 8'h1C, 32'h9);
        k = n_wr;
        irq_seen = 4'h0;
        periph_irq <= 8'h08;
        wait_wr(k + 1);
        periph_irq <= 8'h00;
        apb(1'b1, 8'h0C, 32'h0D00);
        periph_irq <= 8'h08;
        wait_wr(k + 2);
        check("ml_first", wr_a[k], 16'h0C00);
        check("ml_next", wr_a[k + 1], 16'h0D00);
        repeat (4) @(posedge pclk);
        check("ml_irq", irq_seen, 4'h1);
        apb(1'b0, 8'h1C, 32'h0);
        check("ml_keep", rd_v & 32'h89, 32'h89);
        print_verdict;
    end
endmodule
bind dma_ctrl dma_ctrl_asserts chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .periph_irq(periph_irq), .nmi_in(nmi_in), .nmi_ack_allow(nmi_ack_allow),
    .transfer_end_irq(transfer_end_irq), .bus_req(bus_req), .bus_write(bus_write), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_ram(bus_ram), .bus_rdata(bus_rdata));
